// ===== core/dia_audio_out.v
/*
  Audio output path: link audio words are sampled from the link pins,
  buffered, sorted into per-line left/right slots and sent out as I2S on
  four data lines with bit clock, word select and a master clock.
  Assumes link pins change on the falling edge of i_link_clk and the
  register port is driven from logic on i_sys_clk.
*/
`timescale 1ns/1ps
`default_nettype none
`include "dia_consts.vh"
module dia_audio_out (
  input  wire        i_sys_clk,
  input  wire        i_reset_n,
  input  wire        i_link_clk,
  input  wire        i_link_valid,
  input  wire [26:0] i_link_word,
  input  wire        i_link_island,
  input  wire        i_legacy_ser,
  input  wire        i_video_18bit,
  input  wire [7:0]  i_pclk_mhz,
  input  wire [7:0]  i_reg_addr,
  input  wire        i_reg_wr_en,
  input  wire [7:0]  i_reg_wdata,
  output wire [7:0]  o_reg_rdata,
  output wire        o_link_ready,
  output wire        o_audio_bit_clk,
  output wire        o_audio_word_select,
  output wire        o_audio_master_clk,
  output wire        o_audio_data_line_a,
  output wire        o_audio_data_line_b,
  output wire        o_audio_data_line_c,
  output wire        o_audio_data_line_d
);
  // active lines from transport and partner type
  function [3:0] dia_lane_mask;
    input frame_mode;
    input legacy;
    input v18;
    begin
      if (frame_mode) begin
        dia_lane_mask = 4'h1;
      end else if (legacy) begin
        dia_lane_mask = v18 ? 4'h3 : 4'h1;
      end else begin
        dia_lane_mask = 4'hF;
      end
    end
  endfunction

  // smallest legal tick divider not below the request, or DIA_DIV_MAX when no legal divider is
  function [3:0] dia_pick_div;
    input [3:0] req;
    input [7:0] pclk;
    integer     k;
    integer     res;
    integer     n;
    begin
      n   = req;
      res = `DIA_DIV_MAX;
      for (k = `DIA_DIV_MAX; k >= `DIA_DIV_MIN; k = k - 1) begin
        if (k >= n && k * 4 * pclk >= `DIA_SYS_CLK_MHZ) begin
          res = k;
        end
      end
      dia_pick_div = res[3:0];
    end
  endfunction

  // link pins: two-stage synchronisers
  reg        lclk_s1_q;
  reg        lclk_s2_q;
  reg        lclk_s3_q;
  reg        lval_s1_q;
  reg        lval_s2_q;
  reg [26:0] lword_s1_q;
  reg [26:0] lword_s2_q;
  reg [2:0]  strap_s1_q;
  reg [2:0]  strap_s2_q;
  reg [7:0]  pclk_s1_q;
  reg [7:0]  pclk_s2_q;

  always @(posedge i_sys_clk) begin
    if (!i_reset_n) begin
      lclk_s1_q  <= 1'b0;
      lclk_s2_q  <= 1'b0;
      lclk_s3_q  <= 1'b0;
      lval_s1_q  <= 1'b0;
      lval_s2_q  <= 1'b0;
      lword_s1_q <= 27'h0000000;
      lword_s2_q <= 27'h0000000;
      strap_s1_q <= 3'h1;
      strap_s2_q <= 3'h1;
      pclk_s1_q  <= 8'h00;
      pclk_s2_q  <= 8'h00;
    end else begin
      lclk_s1_q  <= i_link_clk;
      lclk_s2_q  <= lclk_s1_q;
      lclk_s3_q  <= lclk_s2_q;
      lval_s1_q  <= i_link_valid;
      lval_s2_q  <= lval_s1_q;
      lword_s1_q <= i_link_word;
      lword_s2_q <= lword_s1_q;
      strap_s1_q <= {i_video_18bit, i_legacy_ser, i_link_island};
      strap_s2_q <= strap_s1_q;
      pclk_s1_q  <= i_pclk_mhz;
      pclk_s2_q  <= pclk_s1_q;
    end
  end

  wire link_rise = lclk_s2_q & ~lclk_s3_q;

  // registers
  reg [7:0] pll_ctrl_q;
  reg [7:0] mclk_ctrl_q;
  reg [7:0] rdata_q;
  reg       link_ready_q;

  // mode is loaded from the far end unless software disables audio config
  wire       frame_mode = pll_ctrl_q[`DIA_BIT_CFG_OFF] | ~strap_s2_q[0];
  wire [3:0] lane_on    = dia_lane_mask(frame_mode, strap_s2_q[1], strap_s2_q[2]);
  wire       pll_off    = pll_ctrl_q[`DIA_BIT_PLL_OFF];

  always @(posedge i_sys_clk) begin
    if (!i_reset_n) begin
      pll_ctrl_q  <= `DIA_PLL_CTRL_RESET;
      mclk_ctrl_q <= `DIA_MCLK_CTRL_RESET;
      rdata_q     <= 8'h00;
    end else begin
      if (i_reg_wr_en && i_reg_addr == `DIA_OFS_PLL_CTRL) begin
        pll_ctrl_q <= {i_reg_wdata[7], 6'h00, i_reg_wdata[0]};
      end
      // ratio field only steers the clock once the override bit is set
      if (i_reg_wr_en && i_reg_addr == `DIA_OFS_MCLK_CTRL) begin
        mclk_ctrl_q <= i_reg_wdata;
      end
      case (i_reg_addr)
        `DIA_OFS_PLL_CTRL:  rdata_q <= {pll_ctrl_q[7], 1'b0, lane_on, 1'b0, pll_ctrl_q[0]};
        `DIA_OFS_MCLK_CTRL: rdata_q <= mclk_ctrl_q;
        default:            rdata_q <= 8'h00;
      endcase
    end
  end

  // buffer between link and slots
  wire        fifo_in_ready;
  wire        fifo_out_valid;
  wire [26:0] fifo_out_data;
  wire        drain_ready;

  dia_fifo #(
    .WIDTH (`DIA_WORD_W),
    .DEPTH (`DIA_FIFO_DEPTH),
    .AW    (3)
  ) u_fifo (
    .i_sys_clk   (i_sys_clk),
    .i_reset_n   (i_reset_n),
    .i_in_valid  (link_rise & lval_s2_q),
    .o_in_ready  (fifo_in_ready),
    .i_in_data   (lword_s2_q),
    .o_out_valid (fifo_out_valid),
    .i_out_ready (drain_ready),
    .o_out_data  (fifo_out_data)
  );

  always @(posedge i_sys_clk) begin
    if (!i_reset_n) begin
      link_ready_q <= 1'b0;
    end else begin
      link_ready_q <= fifo_in_ready;
    end
  end

  // word: [26:25] line, [24] right channel, [23:0] sample
  wire [1:0] w_line = fifo_out_data[26:25];
  wire [2:0] w_slot = fifo_out_data[26:24];
  reg [23:0] hold_q [0:7];
  reg [7:0]  slot_v_q;
  // stalls while the slot still holds an unsent sample, so the buffer fills
  assign drain_ready = ~lane_on[w_line] | ~slot_v_q[w_slot];
  wire   drain_take  = fifo_out_valid & drain_ready & lane_on[w_line];

  // clock generation
  reg [3:0] ndiv_q;
  reg [3:0] divcnt_q;
  reg [1:0] sub_q;
  reg       bclk_q;
  reg       mclk_q;
  reg       ws_q;
  reg [4:0] bitcnt_q;
  reg [31:0] sh_q [0:3];
  reg [3:0] data_q;

  wire       tick = (divcnt_q == ndiv_q - 4'h1);
  wire       fall = tick & (sub_q == 2'h3) & bclk_q;
  // band of the bit clock: lowest band runs slowest
  wire [1:0] band = (ndiv_q >= 4'h7) ? 2'h0 :
                    (ndiv_q >= 4'h4) ? 2'h1 :
                    (ndiv_q >= 4'h2) ? 2'h2 : 2'h3;
  wire [2:0] code = mclk_ctrl_q[`DIA_RATIO_HI:`DIA_RATIO_LO];
  wire [2:0] diff = code - {1'b0, band};
  // x1 = 0, x2 = 1, x4 = 2
  wire [1:0] ratio = !mclk_ctrl_q[`DIA_BIT_MCLK_OVR] ? `DIA_RATIO_X2 :
                     (code < {1'b0, band}) ? 2'h0 :
                     (diff > 3'h2) ? 2'h2 : diff[1:0];
  wire       mclk_tgl = tick & ((ratio == 2'h2) |
                                (ratio == 2'h1 & sub_q[0]) |
                                (ratio == 2'h0 & sub_q == 2'h3));

  integer l;

  always @(posedge i_sys_clk) begin
    if (!i_reset_n) begin
      ndiv_q   <= 4'h6;
      divcnt_q <= 4'h0;
      sub_q    <= 2'h0;
      bclk_q   <= 1'b0;
      mclk_q   <= 1'b0;
      ws_q     <= 1'b1;
      bitcnt_q <= 5'h1F;
      data_q   <= 4'h0;
      slot_v_q <= 8'h00;
      for (l = 0; l < 4; l = l + 1) begin
        sh_q[l] <= 32'h00000000;
      end
    end else begin
      // divider limited to the legal bit clock band
      ndiv_q <= dia_pick_div(mclk_ctrl_q[`DIA_DIV_HI:`DIA_DIV_LO], pclk_s2_q);
      if (tick) begin
        divcnt_q <= 4'h0;
        sub_q    <= sub_q + 2'h1;
      end else begin
        divcnt_q <= divcnt_q + 4'h1;
      end
      if (tick && sub_q == 2'h3) begin
        bclk_q <= ~bclk_q;
      end
      // master clock edges fall only on ticks while the pll is on, at the rate set by ratio, which keeps it locked to the bit clock
      if (pll_off) begin
        mclk_q <= 1'b0;
      end else if (mclk_tgl) begin
        mclk_q <= ~mclk_q;
      end
      if (fall) begin
        bitcnt_q <= bitcnt_q + 5'h01;
        if (bitcnt_q == 5'h1F) begin
          ws_q <= ~ws_q;
        end
        for (l = 0; l < 4; l = l + 1) begin
          data_q[l] <= sh_q[l][31];
          if (bitcnt_q == 5'h1F) begin
            // missing sample goes out as silence
            if (lane_on[l] && slot_v_q[{l[1:0], ~ws_q}]) begin
              sh_q[l] <= {hold_q[{l[1:0], ~ws_q}], 8'h00};
              slot_v_q[{l[1:0], ~ws_q}] <= 1'b0;
            end else begin
              sh_q[l] <= 32'h00000000;
            end
          end else begin
            sh_q[l] <= {sh_q[l][30:0], 1'b0};
          end
        end
      end
      if (drain_take) begin
        slot_v_q[w_slot] <= 1'b1;
      end
    end
  end

  always @(posedge i_sys_clk) begin
    if (drain_take) begin
      hold_q[w_slot] <= fifo_out_data[23:0];
    end
  end

  assign o_reg_rdata         = rdata_q;
  assign o_link_ready        = link_ready_q;
  assign o_audio_bit_clk     = bclk_q;
  assign o_audio_word_select = ws_q;
  assign o_audio_master_clk  = mclk_q;
  assign o_audio_data_line_a = data_q[0];
  assign o_audio_data_line_b = data_q[1];
  assign o_audio_data_line_c = data_q[2];
  assign o_audio_data_line_d = data_q[3];
endmodule // dia_audio_out
`default_nettype wire

// ===== core/dia_consts.vh
/*
  Constants for the deserializer audio output block: register offsets,
  field positions, reset values, link word layout and bit clock limits.
  Assumes a 100 MHz system clock and an 8-bit local register port.
*/
`ifndef DIA_CONSTS_VH
`define DIA_CONSTS_VH

`define DIA_OFS_PLL_CTRL     8'h2B
`define DIA_OFS_MCLK_CTRL    8'h3A
`define DIA_PLL_CTRL_RESET   8'h00
`define DIA_MCLK_CTRL_RESET  8'h06
`define DIA_BIT_PLL_OFF      7
`define DIA_BIT_CFG_OFF      0
`define DIA_MASK_LO          2
`define DIA_MASK_HI          5
`define DIA_BIT_MCLK_OVR     7
`define DIA_RATIO_HI         6
`define DIA_RATIO_LO         4
`define DIA_DIV_HI           3
`define DIA_DIV_LO           0
`define DIA_RATIO_X2         2'h1

`define DIA_SYS_CLK_MHZ      100
`define DIA_SYS_CLK_KHZ      100000
`define DIA_BCLK_MIN_KHZ     1000
`define DIA_BCLK_MAX_KHZ     13000
`define DIA_TICKS_PER_BCLK   8
`define DIA_DIV_MIN  ((`DIA_SYS_CLK_KHZ + `DIA_TICKS_PER_BCLK*`DIA_BCLK_MAX_KHZ - 1) / (`DIA_TICKS_PER_BCLK*`DIA_BCLK_MAX_KHZ))
`define DIA_DIV_MAX  (`DIA_SYS_CLK_KHZ / (`DIA_TICKS_PER_BCLK*`DIA_BCLK_MIN_KHZ))

`define DIA_WORD_W           27
`define DIA_SAMPLE_W         24
`define DIA_FIFO_DEPTH       8
`define DIA_SLOT_BITS        32

`endif

// ===== core/dia_fifo.v
/*
  Small synchronous FIFO with valid/ready on both sides.
  Assumes one clock, synchronous active-low reset; DEPTH a power of two.
*/
`timescale 1ns/1ps
`default_nettype none
module dia_fifo #(
  parameter WIDTH = 27,
  parameter DEPTH = 8,
  parameter AW    = 3
) (
  input  wire             i_sys_clk,
  input  wire             i_reset_n,
  input  wire             i_in_valid,
  output wire             o_in_ready,
  input  wire [WIDTH-1:0] i_in_data,
  output wire             o_out_valid,
  input  wire             i_out_ready,
  output wire [WIDTH-1:0] o_out_data
);
  reg [WIDTH-1:0] mem_q [0:DEPTH-1];
  reg [AW-1:0]    wr_ptr_q;
  reg [AW-1:0]    rd_ptr_q;
  reg [AW:0]      count_q;
  wire            push;
  wire            pop;
  localparam [AW:0] FULL_COUNT = DEPTH;

  assign o_in_ready  = (count_q != FULL_COUNT);
  assign o_out_valid = (count_q != {(AW+1){1'b0}});
  assign o_out_data  = mem_q[rd_ptr_q];
  assign push        = i_in_valid & o_in_ready;
  assign pop         = o_out_valid & i_out_ready;

  always @(posedge i_sys_clk) begin
    if (push) begin
      mem_q[wr_ptr_q] <= i_in_data;
    end
  end

  always @(posedge i_sys_clk) begin
    if (!i_reset_n) begin
      wr_ptr_q <= {AW{1'b0}};
      rd_ptr_q <= {AW{1'b0}};
      count_q  <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_ptr_q <= wr_ptr_q + 1'b1;
      end
      if (pop) begin
        rd_ptr_q <= rd_ptr_q + 1'b1;
      end
      if (push && !pop) begin
        count_q <= count_q + 1'b1;
      end else if (pop && !push) begin
        count_q <= count_q - 1'b1;
      end
    end
  end
endmodule // dia_fifo
`default_nettype wire

// ===== tb/dia_link_src.sv
/* Far-end link source sending audio words.
   Assumes the receiver samples on the link clock rise. */
`timescale 1ns/1ps
`default_nettype none
module dia_link_src (
  output var logic        o_link_clk,
  output var logic        o_link_valid,
  output var logic [26:0] o_link_word,
  output var logic        o_link_island
);
  initial begin
    o_link_clk = 1'b0;
    o_link_valid = 1'b0;
    o_link_word = 27'h0000000;
    o_link_island = 1'b1;
  end
  task automatic set_island(input logic v);
    o_link_island = v;
  endtask
  // clock stands low between words; released lines show junk
  task automatic send(input logic [26:0] w, input int gap);
    o_link_word = w;
    o_link_valid = 1'b1;
    #80 o_link_clk = 1'b1;
    #80 o_link_clk = 1'b0;
    // back-to-back words keep valid up so no line is written twice at once
    if (gap > 0) begin
      o_link_valid = 1'b0;
      o_link_word = ~w;
      #(gap);
    end
  endtask
endmodule // dia_link_src
`default_nettype wire

// ===== tb/dia_props.sv
/* Port checker for dia_audio_out.
   Assumes sync active-low reset on i_sys_clk; bound below. */
`timescale 1ns/1ps
`default_nettype none
module dia_props (
  input wire logic       i_sys_clk,
  input wire logic       i_reset_n,
  input wire logic [7:0] i_reg_addr,
  input wire logic       i_reg_wr_en,
  input wire logic [7:0] i_reg_wdata,
  input wire logic       o_link_ready,
  input wire logic       o_audio_bit_clk,
  input wire logic       o_audio_word_select,
  input wire logic       o_audio_master_clk,
  input wire logic       o_audio_data_line_a,
  input wire logic       o_audio_data_line_b,
  input wire logic       o_audio_data_line_c,
  input wire logic       o_audio_data_line_d
);
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_reset_n);
  logic pll_off_q;
  wire  [3:0] lines = {o_audio_data_line_a, o_audio_data_line_b,
                       o_audio_data_line_c, o_audio_data_line_d};
  // pll disable bit mirrored from the write port
  always @(posedge i_sys_clk) begin
    if (!i_reset_n)
      pll_off_q <= 1'b0;
    else if (i_reg_wr_en && i_reg_addr == 8'h2B)
      pll_off_q <= i_reg_wdata[7];
  end
  sequence s_rst_idle;
    !o_link_ready && o_audio_word_select && !o_audio_master_clk;
  endsequence
  sequence s_ready_up;
    s_rst_idle ##1 o_link_ready;
  endsequence
  property p_rst_out;
    $rose(i_reset_n) |-> s_ready_up;
  endproperty
  property p_bclk_hi;
    $rose(o_audio_bit_clk) |-> o_audio_bit_clk[*4];
  endproperty
  property p_bclk_lo;
    $fell(o_audio_bit_clk) |-> !o_audio_bit_clk[*4];
  endproperty
  property p_bclk_slow;
    $rose(o_audio_bit_clk) |-> ##[1:50] $fell(o_audio_bit_clk);
  endproperty
  property p_ws_edge;
    $changed(o_audio_word_select) |-> $fell(o_audio_bit_clk);
  endproperty
  property p_ws_hold;
    $changed(o_audio_word_select) |=> $stable(o_audio_word_select)[*8];
  endproperty
  property p_data_edge;
    $changed(lines) |-> $fell(o_audio_bit_clk);
  endproperty
  property p_mclk_off;
    pll_off_q[*8] |-> !o_audio_master_clk;
  endproperty
  a_rst_out: assert property (p_rst_out)
    else $error("bad outputs after reset");
  a_bclk_hi: assert property (p_bclk_hi)
    else $error("bit clock high too short");
  a_bclk_lo: assert property (p_bclk_lo)
    else $error("bit clock low too short");
  a_bclk_slow: assert property (p_bclk_slow)
    else $error("bit clock too slow");
  a_ws_edge: assert property (p_ws_edge)
    else $error("word select off falling edge");
  a_ws_hold: assert property (p_ws_hold)
    else $error("word select too short");
  a_data_edge: assert property (p_data_edge)
    else $error("data off falling edge");
  a_mclk_off: assert property (p_mclk_off)
    else $error("master clock with pll off");
endmodule // dia_props
bind dia_audio_out dia_props i_dia_props (.i_sys_clk, .i_reset_n,
  .i_reg_addr, .i_reg_wr_en, .i_reg_wdata, .o_link_ready,
  .o_audio_bit_clk, .o_audio_word_select, .o_audio_master_clk,
  .o_audio_data_line_a, .o_audio_data_line_b, .o_audio_data_line_c,
  .o_audio_data_line_d);
`default_nettype wire

// ===== tb/tb_dia_audio_out.sv
/* Bench for dia_audio_out: registers, clocks, I2S data, buffer.
   Assumes dia_link_src drives the link pins. */
`timescale 1ns/1ps
`default_nettype none
module tb_dia_audio_out;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        legacy = 1'b0;
  logic        v18 = 1'b0;
  logic        wr_en = 1'b0;
  logic [7:0]  pclk = 8'h64;
  logic [7:0]  addr = 8'h00;
  logic [7:0]  wdata = 8'h00;
  wire         lclk, lvalid, island, ready, bclk, ws, mclk, da, db, dc, dd;
  wire  [26:0] lword;
  wire  [7:0]  rdata;
  int          num_errors = 0;
  int          num_checks = 0;
  int          cyc = 0;
  int          per, nm;
  logic [23:0] sa, sd;
  dia_link_src i_dia_link_src (.o_link_clk(lclk), .o_link_valid(lvalid),
    .o_link_word(lword), .o_link_island(island));
  dia_audio_out i_dia_audio_out (.i_sys_clk(clk), .i_reset_n(rst_n),
    .i_link_clk(lclk), .i_link_valid(lvalid), .i_link_word(lword),
    .i_link_island(island), .i_legacy_ser(legacy), .i_video_18bit(v18),
    .i_pclk_mhz(pclk), .i_reg_addr(addr), .i_reg_wr_en(wr_en),
    .i_reg_wdata(wdata), .o_reg_rdata(rdata), .o_link_ready(ready),
    .o_audio_bit_clk(bclk), .o_audio_word_select(ws),
    .o_audio_master_clk(mclk), .o_audio_data_line_a(da),
    .o_audio_data_line_b(db), .o_audio_data_line_c(dc),
    .o_audio_data_line_d(dd));
  always #5 clk = ~clk;
  task automatic test_done();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 25000) begin
      num_errors++;
      test_done();
    end
  end
  task automatic check(input string s, input logic [23:0] seen, exp);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH %s exp %h seen %h", s, exp, seen);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, d);
    tick(1);
    addr = a;
    wdata = d;
    wr_en = 1'b1;
    tick(1);
    wr_en = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, exp);
    tick(1);
    addr = a;
    tick(1);
    check($sformatf("reg %h", a), {16'h0000, rdata}, {16'h0000, exp});
  endtask
  // counts over four bit clock periods, sampled on the system clock
  task automatic measure();
    logic pb, pm;
    int nb;
    nb = 0;
    nm = 0;
    per = 0;
    pb = bclk;
    pm = mclk;
    while (nb < 5) begin
      tick(1);
      if (nb > 0) begin
        per++;
        nm += int'(mclk && !pm);
      end
      nb += int'(bclk && !pb);
      pb = bclk;
      pm = mclk;
    end
  endtask
  task automatic t_modes();
    logic [7:0] w[5] = '{8'h00, 8'hC3, 8'h00, 8'h00, 8'h00};
    logic [7:0] m[5] = '{8'h3C, 8'h85, 8'h04, 8'h04, 8'h0C};
    logic [2:0] s[5] = '{3'b100, 3'b100, 3'b000, 3'b110, 3'b111};
    rd(8'h3A, 8'h06);
    wr(8'h10, 8'hFF);
    rd(8'h10, 8'h00);
    for (int i = 0; i < 5; i++) begin
      i_dia_link_src.set_island(s[i][2]);
      legacy = s[i][1];
      v18 = s[i][0];
      wr(8'h2B, w[i]);
      tick(4);
      rd(8'h2B, m[i]);
    end
    i_dia_link_src.set_island(1'b1);
    legacy = 1'b0;
    v18 = 1'b0;
    wr(8'h2B, 8'h00);
    $display("t_modes done");
  endtask
  task automatic t_ratio();
    logic [7:0] w[7] = '{8'h06, 8'h87, 8'h97, 8'hA7, 8'h27, 8'hD1, 8'h81};
    int r[7] = '{2, 1, 2, 4, 2, 4, 1};
    int p[7] = '{48, 56, 56, 56, 56, 8, 24};
    for (int i = 0; i < 7; i++) begin
      pclk = (i == 6) ? 8'h0A : 8'h64;
      wr(8'h3A, w[i]);
      tick(200);
      measure();
      check("mclk rises", 24'(nm), 24'(4 * r[i]));
      check("bclk period", 24'(per), 24'(4 * p[i]));
    end
    pclk = 8'h64;
    wr(8'h3A, 8'h81);
    $display("t_ratio done");
  endtask
  task automatic t_pll();
    wr(8'h2B, 8'h80);
    nm = 0;
    tick(20);
    repeat (200) begin
      tick(1);
      if (mclk !== 1'b0)
        nm++;
    end
    check("mclk idle", 24'(nm), 24'h000000);
    wr(8'h2B, 8'h00);
    $display("t_pll done");
  endtask
  task automatic t_audio(input logic [7:0] cfg, input logic [23:0] ed);
    wr(8'h2B, cfg);
    tick(8);
    @(posedge ws);
    #1;
    i_dia_link_src.send({2'h0, 1'b0, 24'hA5C381}, 0);
    i_dia_link_src.send({2'h3, 1'b0, 24'h5A3C7E}, 80);
    // one bit of delay after word select, then MSB first
    @(negedge ws);
    @(posedge bclk);
    repeat (24) begin
      @(posedge bclk);
      sa = {sa[22:0], da};
      sd = {sd[22:0], dd};
    end
    check("line a", sa, 24'hA5C381);
    check("line d", sd, ed);
    $display("t_audio done");
  endtask
  task automatic t_fill();
    repeat (12) i_dia_link_src.send({2'h0, 1'b1, 24'h00F00F}, 0);
    tick(4);
    check("ready full", {23'h0, ready}, 24'h0);
    tick(7000);
    check("ready drained", {23'h0, ready}, 24'h1);
    $display("t_fill done");
  endtask
  initial begin
    tick(20);
    rst_n = 1'b1;
    t_modes();
    t_ratio();
    t_pll();
    t_audio(8'h00, 24'h5A3C7E);
    t_audio(8'h01, 24'h000000);
    wr(8'h2B, 8'h00);
    t_fill();
    test_done();
  end
endmodule // tb_dia_audio_out
`default_nettype wire
